/* File: bench/tb_uart_trigger_decoder.sv */
// Purpose: self-checking bench for the serial trigger decoder
// Assumes: a small bit divider keeps words short
// Notes: expected values come from the bench's own model
`timescale 1ns/1ns
`include "uart_trig_regs.svh"
`define CHECK(g, e) check_val(32'(g), 32'(e));
module tb_uart_trigger_decoder import uart_trig_pkg::*; ;
  localparam int DIV = 8;
  logic i_mclk, i_rstn, i_wr, i_rd, o_trigger, tx, rx;
  logic [7:0] i_addr, v;
  logic [31:0] i_wdata, o_rdata, d;
  int n_fail, samples_checked, trig_count, par_cfg, lsb_cfg, n_trig;
  logic [7:0] ra [8] = '{`R_STATUS, `R_CTRL, `R_CFG, `R_BAUDDIV,
    `R_MASK, `R_ENDWORD, `R_TIMEOUT, 8'h3F};
  logic [31:0] rv [8] = '{32'h0, `CTRL_RST, `CFG_RST, `BAUDDIV_RST,
    32'hFF, 32'h0A, `TIMEOUT_RST, 32'h0};
  uart_line_model tx_m (.i_mclk(i_mclk), .o_line(tx));
  uart_line_model rx_m (.i_mclk(i_mclk), .o_line(rx));
  uart_trigger_decoder #(.PAT_WORDS(4)) dut (.i_mclk(i_mclk),
    .i_rstn(i_rstn), .i_tx(tx), .i_rx(rx), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_trigger(o_trigger));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // counted on the falling edge, away from the launching edge
  always @(negedge i_mclk) if (o_trigger === 1'b1) trig_count++;
  task automatic complete_run;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    i_addr <= a;
    i_wdata <= x;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] x);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    x = o_rdata;
    @(posedge i_mclk);
  endtask
  function automatic int cmp(input int op, input int a, input int b);
    case (op)
      0: return int'(a == b);
      1: return int'(a != b);
      2: return int'(a < b);
      3: return int'(a <= b);
      4: return int'(a > b);
      default: return int'(a >= b);
    endcase
  endfunction
  task automatic setup(input int md, input int op, input int src,
      input int par, input int pk);
    par_cfg = par;
    wr(`R_CFG, 32'(8 | par << 4 | lsb_cfg << 9 | pk << 10));
    wr(`R_CTRL, 32'(op << 5 | md << 2 | src << 1 | 1));
    repeat (300) @(posedge i_mclk);
    trig_count = 0;
  endtask
  task automatic trig(input int n);
    repeat (40) @(posedge i_mclk);
    `CHECK(trig_count, n)
    n_trig += n;
    trig_count = 0;
  endtask
  task automatic word(input logic ln, input logic [7:0] w, input logic bp,
      input logic bs);
    int k;
    logic [31:0] st, t0, t1;
    if (ln) rx_m.send({1'b0, w}, 8, par_cfg, DIV, lsb_cfg[0], bp, bs);
    else tx_m.send({1'b0, w}, 8, par_cfg, DIV, lsb_cfg[0], bp, bs);
    st = 32'h0;
    for (k = 0; k < 50 && st[6] !== 1'b1; k++) rd_reg(`R_STATUS, st);
    if (k == 50) begin
      n_fail++;
      complete_run();
    end
    `CHECK(st, {25'h0, 2'b10 | ln, 2'b00, bp && par_cfg != 0, bs, 1'b0})
    rd_reg(`R_WORD, d);
    `CHECK(d, w)
    rd_reg(`R_RATE, d);
    `CHECK(d, DIV)
    rd_reg(`R_TSTART, t0);
    rd_reg(`R_TSTOP, t1);
    `CHECK(t1 - t0 >= 9 * DIV && t1 - t0 <= 11 * DIV, 1)
  endtask
  initial begin
    i_rstn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    n_fail = 0;
    samples_checked = 0;
    trig_count = 0;
    n_trig = 0;
    lsb_cfg = 1;
    par_cfg = 2;
    void'($urandom(52625));
    repeat (8) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    wr(`R_STATUS, 32'hFFFF_FFFF);
    foreach (ra[i]) begin
      rd_reg(ra[i], d);
      `CHECK(d, rv[i])
    end
    wr(`R_BAUDDIV, DIV);
    wr(`R_TIMEOUT, 40);
    setup(0, 0, 1, 2, 0);
    word(1'b1, 8'($urandom), 0, 0);
    trig(1);
    word(1'b0, 8'h00, 0, 0);
    trig(0);
    setup(3, 0, 0, 2, 0);
    word(1'b0, 8'($urandom), 1, 0);
    trig(1);
    word(1'b0, 8'h5A, 0, 0);
    trig(0);
    setup(3, 0, 0, 0, 0);
    word(1'b0, 8'h5A, 1, 0);
    trig(0);
    setup(5, 0, 0, 2, 0);
    word(1'b0, 8'($urandom), 0, 1);
    trig(1);
    setup(4, 0, 0, 2, 0);
    tx_m.hold(1'b0, 30 * DIV);
    tx_m.hold(1'b1, DIV);
    trig(1);
    rd_reg(`R_STATUS, d);
    `CHECK(d[4], 1)
    // abort mid-word, keeping the break mode bits
    tx_m.hold(1'b0, 3 * DIV);
    wr(`R_CTRL, 32'h111);
    tx_m.hold(1'b1, DIV);
    rd_reg(`R_STATUS, d);
    `CHECK(d, 32'h48)
    // disarmed start mode must stay quiet
    wr(`R_CTRL, 0);
    repeat (20) @(posedge i_mclk);
    word(1'b0, 8'($urandom), 0, 0);
    trig(0);
    setup(1, 0, 0, 2, 2);
    repeat (2) begin
      word(1'b0, 8'h11, 0, 0);
      word(1'b0, 8'h22, 0, 0);
      trig(1);
    end
    wr(`R_PATTERN, 32'h72);
    wr(`R_OFFSET, 1);
    setup(2, 0, 0, 2, 2);
    word(1'b0, 8'h72, 0, 0);
    word(1'b0, 8'h33, 0, 0);
    trig(0);
    word(1'b0, 8'h33, 0, 0);
    word(1'b0, 8'h72, 0, 0);
    trig(1);
    wr(`R_MASK, 32'hFFFF);
    wr(`R_PATTERN, 32'h1234);
    wr(`R_OFFSET, 0);
    setup(2, 0, 0, 2, 2);
    word(1'b0, 8'h12, 0, 0);
    word(1'b0, 8'h34, 0, 0);
    trig(1);
    wr(`R_MASK, 32'hFF);
    wr(`R_PATTERN, 32'h50);
    wr(`R_OFFSET, 1);
    for (int op = 0; op < 6; op++) begin
      v = op[0] ? 8'h50 : 8'($urandom);
      lsb_cfg = op / 3;
      setup(2, op, 0, 2, 0);
      word(1'b0, v, 0, 0);
      trig(cmp(op, v, 8'h50));
    end
    rd_reg(`R_TRIGCNT, d);
    `CHECK(d, n_trig)
    complete_run();
  end
endmodule

/* File: bench/uart_line_model.sv */
// Purpose: drives one observed serial line like a real transmitter
// Assumes: one bit lasts div cycles of i_mclk
// Notes: the line idles high between words and never floats
`timescale 1ns/1ns
module uart_line_model (
  input wire logic i_mclk,
  output logic o_line
);
  initial o_line = 1'b1;
  task automatic hold(input logic lvl, input int cyc);
    o_line <= lvl;
    repeat (cyc) @(posedge i_mclk);
  endtask
  task automatic send(input logic [8:0] v, input int nb, input int par,
      input int div, input logic lsb, input logic bad_par,
      input logic bad_stop);
    logic p;
    p = ^(v & ((9'h001 << nb) - 9'h001));
    case (par)
      1: p = ~p;
      3: p = 1'b1;
      4: p = 1'b0;
      default: ;
    endcase
    @(posedge i_mclk);
    hold(1'b0, div);
    for (int i = 0; i < nb; i++) hold(v[lsb ? i : nb - 1 - i], div);
    if (par != 0) hold(p ^ bad_par, div);
    hold(~bad_stop, div);
    o_line <= 1'b1;
  endtask
endmodule

/* File: bench/uart_trigger_decoder_properties.sv */
// Purpose: port-level properties of the serial trigger decoder
// Assumes: sees the decoder's top ports only
// Notes: shadow copies of written registers predict read data
`timescale 1ns/1ns
`include "uart_trig_regs.svh"
module uart_trigger_decoder_checker #(
  parameter int PAT_WORDS = 4
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_tx,
  input wire logic i_rx,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_trigger
);
  // ----
  // shadow state
  // ----
  logic [7:0] ctrl_reg;
  logic [11:0] cfg_reg;
  logic [15:0] div_reg;
  logic [7:0] high_reg;
  logic [3:0] off_reg;
  wire logic sel_line = ctrl_reg[1] ? i_rx : i_tx;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= 8'h00;
      cfg_reg <= 12'h003;
      div_reg <= `BAUDDIV_RST;
    end else if (i_wr) begin
      if (i_addr == `R_CTRL) ctrl_reg <= i_wdata[7:0];
      if (i_addr == `R_CFG) cfg_reg <= i_wdata[11:0];
      if (i_addr == `R_BAUDDIV) div_reg <= i_wdata[15:0];
    end
  end
  // idle length saturates: only a long idle proves a stop was seen
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      high_reg <= 8'h00;
      off_reg <= 4'h0;
    end else begin
      high_reg <= !sel_line ? 8'h00 : high_reg + {7'h0, high_reg != 8'hFF};
      off_reg <= ctrl_reg[0] ? 4'h0 : off_reg + {3'h0, off_reg != 4'hF};
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == 32'h0) else $error("read data not idle");
  a_unmapped_zero: assert property (
    i_rd && i_addr > `R_TRIGCNT |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_trig_single: assert property (
    o_trigger |=> !o_trigger) else $error("trigger wider than one cycle");
  a_status_upper: assert property (
    i_rd && i_addr == `R_STATUS |=> o_rdata[31:7] == 25'h0)
    else $error("status upper bits set");
  a_cfg_back: assert property (
    i_rd && i_addr == `R_CFG |=> o_rdata == {20'h0, $past(cfg_reg)})
    else $error("line setup readback wrong");
  a_ctrl_back: assert property (
    i_rd && i_addr == `R_CTRL |=> o_rdata == {24'h0, $past(ctrl_reg)})
    else $error("control readback wrong");
  a_rate_div: assert property (
    i_rd && i_addr == `R_RATE |=> o_rdata == {16'h0, $past(div_reg)})
    else $error("rate differs from divider");
  a_start_fire: assert property (
    ctrl_reg[0] && ctrl_reg[4:2] == 3'h0 && high_reg == 8'hFF
      && !sel_line |-> ##[2:10] o_trigger)
    else $error("start bit missed");
  a_unarmed_quiet: assert property (
    off_reg == 4'hF |-> !o_trigger) else $error("trigger while disarmed");
endmodule
bind uart_trigger_decoder uart_trigger_decoder_checker #(
  .PAT_WORDS(PAT_WORDS)
) chk (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_tx(i_tx), .i_rx(i_rx),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_trigger(o_trigger)
);

/* File: hdl/uart_trig_pkg.sv */
// Purpose: types shared by the trigger decoder
// Assumes: nothing
// Notes: constants live in uart_trig_regs.svh
package uart_trig_pkg;
  typedef enum logic [2:0] {
    TRG_START, TRG_PACKET, TRG_DATA, TRG_PARITY, TRG_BREAK, TRG_STOPERR
  } trig_mode_t;
  typedef enum logic [2:0] {
    PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE, PAR_IGNORE
  } parity_mode_t;
  typedef enum logic [2:0] {
    OP_EQ, OP_NE, OP_LT, OP_LE, OP_GT, OP_GE
  } cmp_op_t;
  typedef enum logic [1:0] {PKT_NONE, PKT_ENDWORD, PKT_TIMEOUT} pkt_mode_t;
  typedef enum logic [1:0] {STOP_1, STOP_1P5, STOP_2} stop_len_t;
  typedef struct packed {
    logic [3:0] data_bits;
    parity_mode_t parity;
    stop_len_t stop_len;
    logic lsb_first;
    logic [15:0] baud_div;
  } line_cfg_t;
  typedef struct packed {
    logic [8:0] value;
    logic start_fault_state;
    logic stop_fault_state;
    logic parity_fault_state;
    logic incomplete;
    logic brk;
    logic [31:0] t_start;
    logic [31:0] t_stop;
  } word_rec_t;
endpackage

/* File: hdl/uart_trig_regs.svh */
// Purpose: register offsets, reset values, timing counts
// Assumes: plain register port, 8-bit word addresses
// Notes: included by the package users
`ifndef UART_TRIG_REGS_SVH
`define UART_TRIG_REGS_SVH
`define R_CTRL        8'h00
`define R_CFG         8'h01
`define R_BAUDDIV     8'h02
`define R_PATTERN     8'h03
`define R_MASK        8'h04
`define R_OFFSET      8'h05
`define R_ENDWORD     8'h06
`define R_TIMEOUT     8'h07
`define R_STATUS      8'h08
`define R_WORD        8'h09
`define R_TSTART      8'h0A
`define R_TSTOP       8'h0B
`define R_RATE        8'h0C
`define R_TRIGCNT     8'h0D
`define CTRL_RST      32'h0000_0000
`define CFG_RST       32'h0000_0003
`define BAUDDIV_RST   16'h0364
`define TIMEOUT_RST   24'h00_1000
`endif

/* File: hdl/uart_trigger_decoder.sv */
// Purpose: serial line monitor: trigger and per-word decode records
// Assumes: tx/rx pins are asynchronous and idle high
// Notes: word fields read one cycle after the read strobe
`timescale 1ns/1ns
`include "uart_trig_regs.svh"
// Operation
// [RL1] start trigger: first low after stop
// [RL2] packet trigger at packet begin
// [RL3] data trigger: pattern across words
// [RL4] parity trigger only with parity configured
// [RL5] break: line low beyond word
// [RL6] stop error: stop bit low
// [RL7] source selects tx or rx
// [RL8] selectable compare operator
// [RL9] pattern msb first always
// [RL10] offset words skipped before compare
// [RL11] offset needs packet detection
// [RL12] incomplete word flagged at record end
// [RL13] start and stop timestamps
// [RL14] start stop parity fault classes
// [RL15] report rate and source line
// [RL16] far end idles high, low start
// [RL17] 5 to 9 data bits, stop lengths (stop length unused: only the first stop bit is sampled)
// [RL18] parity modes odd even mark space
// [RL19] packets end on word or timeout
// [RL20] centre sampling, resync on start
module uart_trigger_decoder import uart_trig_pkg::*; #(
  parameter int PAT_WORDS = 4
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_tx,
  input wire logic i_rx,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_trigger
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] cfg_reg;
  logic [15:0] bauddiv_reg;
  logic [31:0] pattern_reg;
  logic [31:0] mask_reg;
  logic [7:0] offset_reg;
  logic [8:0] endword_reg;
  logic [23:0] timeout_reg;
  logic [31:0] now_reg;
  logic [15:0] trigcnt_reg;
  logic [1:0] tx_sync_reg;
  logic [1:0] rx_sync_reg;
  logic abort_req_reg;
  word_rec_t last_reg;
  logic last_src_reg;
  logic last_valid_reg;

  // ctrl: [0] arm [1] source rx [4:2] mode [7:5] operator
  //       [8] abort record (self clearing)
  wire trig_mode_t mode = trig_mode_t'(ctrl_reg[4:2]);
  wire cmp_op_t op = cmp_op_t'(ctrl_reg[7:5]);
  wire logic armed = ctrl_reg[0];
  // [RL7] source select
  wire logic src_rx = ctrl_reg[1];
  // cfg: [3:0] data bits [6:4] parity [8:7] stop [9] lsb first [11:10] packets
  wire pkt_mode_t pkt = pkt_mode_t'(cfg_reg[11:10]);
  wire line_cfg_t lcfg = '{data_bits: cfg_reg[3:0],
                           parity: parity_mode_t'(cfg_reg[6:4]),
                           stop_len: stop_len_t'(cfg_reg[8:7]),
                           lsb_first: cfg_reg[9],
                           baud_div: bauddiv_reg};

  // ----------------------------------------
  // receivers
  // ----------------------------------------
  logic tx_start, tx_done, tx_idle, rx_start, rx_done, rx_idle;
  word_rec_t tx_rec, rx_rec;
  uart_word_rx u_tx (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_line(tx_sync_reg[1]),
    .i_cfg(lcfg), .i_now(now_reg), .i_abort(abort_req_reg),
    .o_start(tx_start), .o_done(tx_done), .o_rec(tx_rec), .o_idle(tx_idle)
  );
  uart_word_rx u_rx (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_line(rx_sync_reg[1]),
    .i_cfg(lcfg), .i_now(now_reg), .i_abort(abort_req_reg),
    .o_start(rx_start), .o_done(rx_done), .o_rec(rx_rec), .o_idle(rx_idle)
  );

  wire logic s_start = src_rx ? rx_start : tx_start;
  wire logic s_done = src_rx ? rx_done : tx_done;
  wire logic s_idle = src_rx ? rx_idle : tx_idle;
  wire word_rec_t s_rec = src_rx ? rx_rec : tx_rec;

  // ----------------------------------------
  // packet tracking
  // ----------------------------------------
  logic in_pkt_reg;
  logic [23:0] gap_reg;
  logic [7:0] widx_reg;
  logic [31:0] hist_reg;
  logic brk_seen_reg;
  wire logic pkt_on = (pkt != PKT_NONE);
  // [RL19] end on end word or idle gap
  wire logic end_word = (pkt == PKT_ENDWORD) && s_done &&
                        (s_rec.value == endword_reg);
  wire logic gap_end = (pkt == PKT_TIMEOUT) && s_idle && in_pkt_reg &&
                       (gap_reg >= timeout_reg);
  wire logic pkt_begin = s_start && !in_pkt_reg;

  // [RL9] pattern and history both msb first, newest word lowest
  function automatic logic cmp(input cmp_op_t o, input logic [31:0] a,
                               input logic [31:0] b);
    case (o)
      OP_EQ: cmp = (a == b);
      OP_NE: cmp = (a != b);
      OP_LT: cmp = (a < b);
      OP_LE: cmp = (a <= b);
      OP_GT: cmp = (a > b);
      OP_GE: cmp = (a >= b);
      default: cmp = 1'b0;
    endcase
  endfunction
  wire logic [31:0] hist_next = {hist_reg[23:0], s_rec.value[7:0]};
  // words needed to fill the pattern, from the mask width
  wire logic [2:0] pat_len = mask_reg[31:24] != 8'h00 ? 3'h4 :
                             mask_reg[23:16] != 8'h00 ? 3'h3 :
                             mask_reg[15:8] != 8'h00 ? 3'h2 : 3'h1;
  // [RL10] skip leading words; [RL11] only with packets
  wire logic [7:0] eff_off = pkt_on ? offset_reg : 8'h00;
  wire logic pos_ok = pkt_on ?
    (widx_reg + 8'h01 == eff_off + {5'h00, pat_len}) :
    (widx_reg + 8'h01 >= {5'h00, pat_len});
  // [RL8] operator on masked words
  // [RL3] pattern over words
  wire logic data_hit = s_done && pos_ok && !s_rec.incomplete &&
    cmp(op, hist_next & mask_reg, pattern_reg & mask_reg);

  logic hit;
  always_comb begin
    hit = 1'b0;
    case (mode)
      // [RL1] first low after stop
      TRG_START: hit = s_start;
      // [RL2] packet begin
      TRG_PACKET: hit = pkt_begin && pkt_on;
      TRG_DATA: hit = data_hit;
      // [RL4] gated on parity mode
      TRG_PARITY: hit = s_done && s_rec.parity_fault_state &&
                        (lcfg.parity != PAR_NONE);
      // [RL5] break
      TRG_BREAK: hit = s_rec.brk && !brk_seen_reg;
      // [RL6] stop error
      TRG_STOPERR: hit = s_done && s_rec.stop_fault_state;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_pkt_reg <= 1'b0;
      gap_reg <= 24'h00_0000;
      widx_reg <= 8'h00;
      hist_reg <= 32'h0000_0000;
      brk_seen_reg <= 1'b0;
    end else begin
      brk_seen_reg <= s_rec.brk;
      gap_reg <= s_idle ? gap_reg + 24'h00_0001 : 24'h00_0000;
      if (end_word || gap_end) begin
        in_pkt_reg <= 1'b0;
      end else if (s_start) begin
        in_pkt_reg <= 1'b1;
      end
      if (pkt_begin) begin
        widx_reg <= 8'h00;
        hist_reg <= 32'h0000_0000;
      end else if (s_done) begin
        hist_reg <= hist_next;
        if (widx_reg != 8'hFF)
          widx_reg <= widx_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  wire logic [31:0] rd_mux =
    (i_addr == `R_CTRL) ? ctrl_reg :
    (i_addr == `R_CFG) ? cfg_reg :
    (i_addr == `R_BAUDDIV) ? {16'h0000, bauddiv_reg} :
    (i_addr == `R_PATTERN) ? pattern_reg :
    (i_addr == `R_MASK) ? mask_reg :
    (i_addr == `R_OFFSET) ? {24'h00_0000, offset_reg} :
    (i_addr == `R_ENDWORD) ? {23'h00_0000, endword_reg} :
    (i_addr == `R_TIMEOUT) ? {8'h00, timeout_reg} :
    // [RL14] classification; [RL15] source and rate
    (i_addr == `R_STATUS) ? {25'h000_0000, last_valid_reg, last_src_reg,
      last_reg.brk, last_reg.incomplete, last_reg.parity_fault_state,
      last_reg.stop_fault_state, last_reg.start_fault_state} :
    (i_addr == `R_WORD) ? {23'h00_0000, last_reg.value} :
    (i_addr == `R_TSTART) ? last_reg.t_start :
    (i_addr == `R_TSTOP) ? last_reg.t_stop :
    (i_addr == `R_RATE) ? {16'h0000, bauddiv_reg} :
    (i_addr == `R_TRIGCNT) ? {16'h0000, trigcnt_reg} : 32'h0000_0000;

  wire logic status_rd = i_rd && (i_addr == `R_STATUS);
  wire logic any_done = tx_done | rx_done;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= `CTRL_RST;
      cfg_reg <= `CFG_RST;
      bauddiv_reg <= `BAUDDIV_RST;
      pattern_reg <= 32'h0000_0000;
      mask_reg <= 32'h0000_00FF;
      offset_reg <= 8'h00;
      endword_reg <= 9'h00A;
      timeout_reg <= `TIMEOUT_RST;
      now_reg <= 32'h0000_0000;
      trigcnt_reg <= 16'h0000;
      tx_sync_reg <= 2'b11;
      rx_sync_reg <= 2'b11;
      abort_req_reg <= 1'b0;
      last_reg <= '0;
      last_src_reg <= 1'b0;
      last_valid_reg <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_trigger <= 1'b0;
    end else begin
      tx_sync_reg <= {tx_sync_reg[0], i_tx};
      rx_sync_reg <= {rx_sync_reg[0], i_rx};
      now_reg <= now_reg + 32'h0000_0001;
      o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
      abort_req_reg <= i_wr && (i_addr == `R_CTRL) && i_wdata[8];
      o_trigger <= armed && hit;
      if (armed && hit)
        trigcnt_reg <= trigcnt_reg + 16'h0001;
      // [RL15] last word with line of origin; new word beats read clear
      if (any_done) begin
        last_reg <= tx_done ? tx_rec : rx_rec;
        last_src_reg <= ~tx_done;
        last_valid_reg <= 1'b1;
      end else if (status_rd) begin
        last_valid_reg <= 1'b0;
      end
      if (i_wr) begin
        case (i_addr)
          `R_CTRL: ctrl_reg <= {23'h00_0000, 1'b0, i_wdata[7:0]};
          `R_CFG: cfg_reg <= {20'h0_0000, i_wdata[11:0]};
          `R_BAUDDIV: bauddiv_reg <= i_wdata[15:0];
          `R_PATTERN: pattern_reg <= i_wdata;
          `R_MASK: mask_reg <= i_wdata;
          `R_OFFSET: offset_reg <= i_wdata[7:0];
          `R_ENDWORD: endword_reg <= i_wdata[8:0];
          `R_TIMEOUT: timeout_reg <= i_wdata[23:0];
          default: ;
        endcase
      end
    end
  end
endmodule

/* File: hdl/uart_word_rx.sv */
// Purpose: one serial word receiver with centre sampling and error flags
// Assumes: line already synchronised to i_mclk
// Notes: one instance per line
`timescale 1ns/1ns
`include "uart_trig_regs.svh"
module uart_word_rx import uart_trig_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_line,
  input wire line_cfg_t i_cfg,
  input wire logic [31:0] i_now,
  input wire logic i_abort,
  output logic o_start,
  output logic o_done,
  output word_rec_t o_rec,
  output logic o_idle
);
  typedef enum {S_IDLE, S_START, S_DATA, S_PAR, S_STOP, S_BRK} st_t;
  st_t st_reg;
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [8:0] sh_reg;
  logic ones_reg;
  logic line_d_reg;
  word_rec_t rec_reg;
  wire logic has_par = (i_cfg.parity != PAR_NONE);
  wire logic fall = line_d_reg & ~i_line;
  wire logic [15:0] half = {1'b0, i_cfg.baud_div[15:1]};
  wire logic tick = (cnt_reg == 16'h0000);
  // [RL18] expected parity bit per mode
  wire logic par_exp = (i_cfg.parity == PAR_ODD) ? ~ones_reg :
                       (i_cfg.parity == PAR_EVEN) ? ones_reg :
                       (i_cfg.parity == PAR_MARK);
  wire logic par_chk = (i_cfg.parity != PAR_IGNORE);
  // only the first stop bit is sampled; longer stops read as idle
  // word length in bits including start, used for break detection
  wire logic [3:0] word_bits = i_cfg.data_bits + 4'h2 + {3'h0, has_par};
  wire logic [8:0] sh_in = i_cfg.lsb_first ?
    {i_line, sh_reg[8:1]} : {sh_reg[7:0], i_line};
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= S_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      sh_reg <= 9'h000;
      ones_reg <= 1'b0;
      line_d_reg <= 1'b1;
      rec_reg <= '0;
      o_start <= 1'b0;
      o_done <= 1'b0;
    end else begin
      line_d_reg <= i_line;
      o_start <= 1'b0;
      o_done <= 1'b0;
      cnt_reg <= tick ? i_cfg.baud_div - 16'h0001 : cnt_reg - 16'h0001;
      case (st_reg)
        S_IDLE: begin
          // [RL20] resync on edge
          if (fall) begin
            st_reg <= S_START;
            cnt_reg <= half;
            // [RL13] start timestamp
            rec_reg <= '0;
            rec_reg.t_start <= i_now;
            o_start <= 1'b1;
          end
        end
        S_START: begin
          if (tick) begin
            // [RL14] start fault
            if (i_line) begin
              rec_reg.start_fault_state <= 1'b1;
              rec_reg.t_stop <= i_now;
              o_done <= 1'b1;
              st_reg <= S_IDLE;
            end else begin
              st_reg <= S_DATA;
              bit_reg <= 4'h0;
              sh_reg <= 9'h000;
              ones_reg <= 1'b0;
            end
          end
        end
        S_DATA: begin
          if (tick) begin
            sh_reg <= sh_in;
            ones_reg <= ones_reg ^ i_line;
            bit_reg <= bit_reg + 4'h1;
            // [RL17] configured word width
            if (bit_reg + 4'h1 == i_cfg.data_bits) begin
              st_reg <= has_par ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (tick) begin
            // [RL14] parity fault
            rec_reg.parity_fault_state <= par_chk & (i_line != par_exp);
            bit_reg <= bit_reg + 4'h1;
            st_reg <= S_STOP;
          end
        end
        S_STOP: begin
          if (tick) begin
            // [RL6] stop sampled low
            rec_reg.value <= i_cfg.lsb_first ?
              (sh_reg >> (4'h9 - i_cfg.data_bits)) : sh_reg;
            rec_reg.t_stop <= i_now;
            if (!i_line) begin
              rec_reg.stop_fault_state <= 1'b1;
              st_reg <= S_BRK;
              bit_reg <= bit_reg + 4'h1;
            end else begin
              o_done <= 1'b1;
              st_reg <= S_IDLE;
            end
          end
        end
        S_BRK: begin
          // [RL5] low beyond a word
          if (i_line) begin
            o_done <= 1'b1;
            st_reg <= S_IDLE;
          end else if (tick) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg + 4'h1 > word_bits + 4'h1)
              rec_reg.brk <= 1'b1;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
      // [RL12] record ended early
      if (i_abort && st_reg != S_IDLE) begin
        rec_reg.incomplete <= 1'b1;
        rec_reg.t_stop <= i_now;
        o_done <= 1'b1;
        st_reg <= S_IDLE;
      end
    end
  end
  assign o_rec = rec_reg;
  assign o_idle = (st_reg == S_IDLE);
endmodule
